// ===== rtl/gpm_frame_div.sv
`default_nettype none
module gpm_frame_div (
    input  wire logic       i_ref_clk,
    input  wire logic       i_srst,
    input  wire logic [1:0] i_rate,
    output logic            o_tick
);
    // ----------------------------------------
    // Back-channel frame divider
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } gpm_div_t;
    gpm_div_t   q;
    gpm_div_t   d;
    logic [7:0] lim;

    // One pulse per 30-bit frame period
    always_comb begin
        d = q;
        d.tick = 1'b0;
        case (gpm_pkg::gpm_bc_rate_t'(i_rate))
            gpm_pkg::GPM_BC_50M: lim = 8'(gpm_pkg::BC_FAST_CYC);
            gpm_pkg::GPM_BC_10M: lim = 8'(gpm_pkg::BC_MID_CYC);
            gpm_pkg::GPM_BC_2M5: lim = 8'(gpm_pkg::BC_SLOW_CYC);
            default:             lim = 8'(gpm_pkg::BC_SLOW_CYC);
        endcase
        if (q.cnt >= lim - 8'h01) begin
            d.cnt = 8'h00;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
        if (i_srst) begin
            d = '0;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        q <= d;
    end

    assign o_tick = q.tick;

    sequence fast_tick_s;
        o_tick && (i_rate == 2'b00) && $stable(i_rate);
    endsequence

    fast_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        fast_tick_s |=> !o_tick [*8])
        else $error("frame tick too early");
    fast_period_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        fast_tick_s ##1 (i_rate == 2'b00) [*8] |-> ##[1:4] o_tick)
        else $error("frame tick missing");
endmodule
`default_nettype wire

// ===== rtl/gpm_pkg.sv
`default_nettype none
package gpm_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int unsigned NPIN  = 8;
    localparam int unsigned NPORT = 4;
    localparam int unsigned NFC   = 4;
    localparam int unsigned OD_PIN = 3;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h0e;
    localparam logic [7:0] OFS_IN_DIS = 8'h0f;
    localparam logic [7:0] OFS_CTL0   = 8'h10;
    localparam logic [7:0] OFS_CTL7   = 8'h17;
    localparam logic [7:0] OFS_BC_A   = 8'h6e;
    localparam logic [7:0] OFS_BC_B   = 8'h6f;
    localparam logic [7:0] OFS_PD_DIS = 8'hbe;
    // ----------------------------------------
    // Reset values and fields
    // ----------------------------------------
    localparam logic [7:0] RST_IN_DIS = 8'h00;
    localparam logic [7:0] RST_PD_DIS = 8'h00;
    localparam logic [7:0] RST_CTL    = 8'h00;
    localparam logic [7:0] RST_BC     = 8'h00;
    localparam logic [7:0] OD_MASK    = 8'h08;
    localparam int unsigned CTL_OE_BIT   = 0;
    localparam int unsigned CTL_KIND_LSB = 1;
    localparam int unsigned CTL_VAL_BIT  = 3;
    localparam int unsigned CTL_SEL_LSB  = 4;
    localparam logic [3:0] BC_SRC_INT_FS = 4'h8;
    localparam logic [3:0] BC_SRC_EXT_FS = 4'h9;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_NS      = 50;
    localparam int unsigned FC_LAT_NS   = 225;
    localparam int unsigned FC_LAT_CYC  = FC_LAT_NS / CLK_NS;
    localparam int unsigned FC_PIPE     = FC_LAT_CYC - 2;
    localparam int unsigned BC_FAST_NS  = 600;
    localparam int unsigned BC_MID_NS   = 3000;
    localparam int unsigned BC_SLOW_NS  = 12000;
    localparam int unsigned BC_FAST_CYC = BC_FAST_NS / CLK_NS;
    localparam int unsigned BC_MID_CYC  = BC_MID_NS / CLK_NS;
    localparam int unsigned BC_SLOW_CYC = BC_SLOW_NS / CLK_NS;
    localparam logic [2:0] FC_IVL_ONE  = 3'h1;
    localparam logic [2:0] FC_IVL_TWO  = 3'h2;
    localparam logic [2:0] FC_IVL_MANY = 3'h5;
    // ----------------------------------------
    // Modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        GPM_SRC_REG   = 2'b00,
        GPM_SRC_FC    = 2'b01,
        GPM_SRC_FSYNC = 2'b10,
        GPM_SRC_CTL   = 2'b11
    } gpm_src_t;
    typedef enum logic [1:0] {
        GPM_BC_50M  = 2'b00,
        GPM_BC_10M  = 2'b01,
        GPM_BC_2M5  = 2'b10
    } gpm_bc_rate_t;
endpackage
`default_nettype wire

// ===== rtl/gpm_port.sv
// What this block does
// - Eight pins, each with function control register
// - All pins come up as inputs
// - Open-drain pin 3 lacks input/pulldown bits
// - Reset enables input path, and pulldown on all pins but 3
// - Input-disable bit n disables pin n
// - Status reads pin levels, own drive when input is off
// - Up to four forward signals per port
// - Any forward signal drives any output pin
// - Sample every 1, 2 or 5 frames
// - Forward latency fixed near 225 ns
// - Internal sync or control drives any pin
// - Four back-channel slots per remote serializer
// - Any pin feeds any slot, many slots
// - Sample pins once per 30-bit frame
// - Slow back-channel frame is 12 us
// - Back-channel delay about one frame
// - Frame sync assignable to any slot
// - Slot maps at 0x6E and 0x6F per port
// - Pulldown-disable at 0xBE, input at 0x0F
`default_nettype none
module gpm_port (
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [1:0]  i_rx_port_sel,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic [7:0]  i_pin_in,
    output logic      [7:0]  o_pin_out,
    output logic      [7:0]  o_pin_oe,
    output logic      [7:0]  o_pin_ie,
    output logic      [7:0]  o_pin_pd_en,
    input  wire logic [3:0]  i_fc_frame,
    input  wire logic [15:0] i_fc_data,
    input  wire logic [7:0]  i_fc_linked_count,
    input  wire logic        i_fsync_int,
    input  wire logic        i_ext_fsync,
    input  wire logic        i_int_ctl,
    input  wire logic [1:0]  i_bc_rate,
    output logic             o_bc_tick,
    output logic      [15:0] o_bc_slot
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]                        in_dis;  // Input disables
        logic [7:0]                        pd_dis;  // Pulldown disables
        logic [7:0][7:0]                   ctl;     // Per-pin function
        logic [3:0][7:0]                   bc_a;    // Slots 0,1 per port
        logic [3:0][7:0]                   bc_b;    // Slots 2,3 per port
        logic [3:0][2:0]                   fc_cnt;  // Frames since sample
        logic [15:0]                       fc_hold; // Last forward values
        logic [gpm_pkg::FC_PIPE-1:0][15:0] fc_pipe; // Latency line
        logic [7:0]                        pin_out; // Pad drive value
        logic [7:0]                        pin_oe;  // Pad drive enable
        logic [7:0]                        pin_ie;  // Input buffer on
        logic [7:0]                        pin_pd;  // Pulldown on
        logic [7:0]                        status;  // Pin levels
        logic [15:0]                       bc_slot; // Back-channel bits
        logic                              bc_tick; // Frame marker
        logic [7:0]                        rdata;   // Read answer
    } gpm_state_t;

    gpm_state_t q;        // Registered state
    gpm_state_t d;        // Next state
    logic [8:0] lvl;      // Synchronised pins and ext sync
    logic       bc_tick;  // Frame pulse from divider
    logic [15:0] fc_out;  // Delayed forward values

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Frames between forward samples
    function automatic logic [2:0] fc_ivl(input logic [1:0] cnt);
        case (cnt)
            2'b00:   fc_ivl = gpm_pkg::FC_IVL_ONE;
            2'b01:   fc_ivl = gpm_pkg::FC_IVL_TWO;
            default: fc_ivl = gpm_pkg::FC_IVL_MANY;
        endcase
    endfunction

    // Pads and external sync into clock domain
    gpm_sync #(
        .W (9)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_async   ({i_ext_fsync, i_pin_in}),
        .o_level   (lvl)
    );

    // Back-channel frame timing
    gpm_frame_div u_div (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_rate    (i_bc_rate),
        .o_tick    (bc_tick)
    );

    // Forward values after the fixed delay
    assign fc_out = q.fc_pipe[gpm_pkg::FC_PIPE-1];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic       v;
        logic [3:0] code;
        logic [2:0] ivl;
        v = 1'b0;
        code = 4'h0;
        ivl = 3'h0;
        d = q;

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (i_reg_wr) begin
            // Pin 3 has no input or pulldown bit
            if (i_reg_addr == gpm_pkg::OFS_IN_DIS) begin
                d.in_dis = i_reg_wdata & ~gpm_pkg::OD_MASK;
            end
            if (i_reg_addr == gpm_pkg::OFS_PD_DIS) begin
                d.pd_dis = i_reg_wdata & ~gpm_pkg::OD_MASK;
            end
            // Function control, one per pin
            if (i_reg_addr[7:3] == gpm_pkg::OFS_CTL0[7:3]) begin
                d.ctl[i_reg_addr[2:0]] = i_reg_wdata;
            end
            // Slot maps, banked by port
            if (i_reg_addr == gpm_pkg::OFS_BC_A) begin
                d.bc_a[i_rx_port_sel] = i_reg_wdata;
            end
            if (i_reg_addr == gpm_pkg::OFS_BC_B) begin
                d.bc_b[i_rx_port_sel] = i_reg_wdata;
            end
        end

        // ----------------------------------------
        // Register reads, unmapped read as zero
        // ----------------------------------------
        if (i_reg_rd) begin
            if (i_reg_addr == gpm_pkg::OFS_STATUS) begin
                d.rdata = q.status;
            end else if (i_reg_addr == gpm_pkg::OFS_IN_DIS) begin
                d.rdata = q.in_dis;
            end else if (i_reg_addr == gpm_pkg::OFS_PD_DIS) begin
                d.rdata = q.pd_dis;
            end else if (i_reg_addr[7:3] == gpm_pkg::OFS_CTL0[7:3]) begin
                d.rdata = q.ctl[i_reg_addr[2:0]];
            end else if (i_reg_addr == gpm_pkg::OFS_BC_A) begin
                d.rdata = q.bc_a[i_rx_port_sel];
            end else if (i_reg_addr == gpm_pkg::OFS_BC_B) begin
                d.rdata = q.bc_b[i_rx_port_sel];
            end else begin
                // Nothing mapped here
                d.rdata = 8'h00;
            end
        end

        // ----------------------------------------
        // Forward channel: accept a port's four bits
        // every 1, 2 or 5 frames, hold in between
        // ----------------------------------------
        for (int p = 0; p < gpm_pkg::NPORT; p++) begin
            ivl = fc_ivl(i_fc_linked_count[2*p +: 2]);
            if (i_fc_frame[p]) begin
                // Take the frame once the interval is up
                if (q.fc_cnt[p] >= ivl - 3'h1) begin
                    d.fc_cnt[p] = 3'h0;
                    d.fc_hold[4*p +: 4] = i_fc_data[4*p +: 4];
                end else begin
                    d.fc_cnt[p] = q.fc_cnt[p] + 3'h1;
                end
            end
        end

        // Fixed delay, independent of interval
        d.fc_pipe[0] = q.fc_hold;
        for (int k = 1; k < gpm_pkg::FC_PIPE; k++) begin
            d.fc_pipe[k] = q.fc_pipe[k-1];
        end

        // ----------------------------------------
        // Pin drive and status per pin
        // ----------------------------------------
        for (int i = 0; i < gpm_pkg::NPIN; i++) begin
            // Pick this pin's value source
            code = q.ctl[i][gpm_pkg::CTL_SEL_LSB +: 4];
            case (gpm_pkg::gpm_src_t'(q.ctl[i][gpm_pkg::CTL_KIND_LSB +: 2]))
                gpm_pkg::GPM_SRC_REG:   v = q.ctl[i][gpm_pkg::CTL_VAL_BIT];
                gpm_pkg::GPM_SRC_FC:    v = fc_out[code];
                gpm_pkg::GPM_SRC_FSYNC: v = i_fsync_int;
                gpm_pkg::GPM_SRC_CTL:   v = i_int_ctl;
                default:                v = 1'b0;
            endcase
            if (i == gpm_pkg::OD_PIN) begin
                // Open drain: only pulls low
                d.pin_out[i] = 1'b0;
                d.pin_oe[i] = q.ctl[i][gpm_pkg::CTL_OE_BIT] & ~v;
                d.pin_ie[i] = 1'b1;
                d.pin_pd[i] = 1'b0;
            end else begin
                d.pin_out[i] = v;
                d.pin_oe[i] = q.ctl[i][gpm_pkg::CTL_OE_BIT];
                d.pin_ie[i] = ~q.in_dis[i];
                d.pin_pd[i] = ~q.pd_dis[i];
            end
            // Pad level, or own drive when input is off
            if (q.pin_ie[i]) begin
                d.status[i] = lvl[i];
            end else begin
                d.status[i] = q.pin_oe[i] & q.pin_out[i];
            end
        end

        // ----------------------------------------
        // Back channel: sample once per frame
        // ----------------------------------------
        d.bc_tick = bc_tick;
        if (bc_tick) begin
            // Every slot of every port
            for (int s = 0; s < gpm_pkg::NPORT * gpm_pkg::NFC; s++) begin
                if ((s % 4) < 2) begin
                    code = q.bc_a[s/4][4*(s%2) +: 4];
                end else begin
                    code = q.bc_b[s/4][4*(s%2) +: 4];
                end
                // Pin level, sync, or idle zero
                if (code < 4'h8) begin
                    v = lvl[code[2:0]];
                end else if (code == gpm_pkg::BC_SRC_INT_FS) begin
                    v = i_fsync_int;
                end else if (code == gpm_pkg::BC_SRC_EXT_FS) begin
                    v = lvl[8];
                end else begin
                    v = 1'b0;
                end
                d.bc_slot[s] = v;
            end
        end

        // ----------------------------------------
        // Synchronous reset
        // ----------------------------------------
        if (i_srst) begin
            // Config back to inputs, pulldowns on except pin 3
            d = '0;
            d.in_dis = gpm_pkg::RST_IN_DIS;
            d.pd_dis = gpm_pkg::RST_PD_DIS;
            d.ctl = {gpm_pkg::NPIN{gpm_pkg::RST_CTL}};
            d.bc_a = {gpm_pkg::NPORT{gpm_pkg::RST_BC}};
            d.bc_b = {gpm_pkg::NPORT{gpm_pkg::RST_BC}};
            d.pin_ie = ~gpm_pkg::RST_IN_DIS;
            d.pin_pd = ~gpm_pkg::RST_PD_DIS & ~gpm_pkg::OD_MASK;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        q <= d;
    end

    // Outputs straight from flops
    assign o_reg_rdata = q.rdata;
    assign o_pin_out   = q.pin_out;
    assign o_pin_oe    = q.pin_oe;
    assign o_pin_ie    = q.pin_ie;
    assign o_pin_pd_en = q.pin_pd;
    assign o_bc_tick   = q.bc_tick;
    assign o_bc_slot   = q.bc_slot;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    reset_input_a: assert property (@(posedge i_ref_clk)
        $past(i_srst) |-> (o_pin_oe == 8'h00) && (o_pin_ie == 8'hff)
            && (o_pin_pd_en == 8'hf7))
        else $error("pins not inputs after reset");

    od_pin_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !o_pin_out[3] && o_pin_ie[3] && !o_pin_pd_en[3])
        else $error("open-drain pin misdriven");

    in_disable_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == 8'h0f) ##1 !i_srst
            |=> o_pin_ie == (~$past(i_reg_wdata, 2) | 8'h08))
        else $error("input enable not following write");

    // Port 2 frame taken at one sample per frame
    sequence fc_take_s;
        i_fc_frame[2] && (i_fc_linked_count[5:4] == 2'b00);
    endsequence

    fc_every_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        fc_take_s |=> q.fc_hold[11:8] == $past(i_fc_data[11:8]))
        else $error("single signal not sampled every frame");

    // Pin 1 set to drive forward bit 9
    fc_reach_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        fc_take_s ##3 (q.ctl[1] == 8'h93) |=> o_pin_out[1] == $past(i_fc_data[9], 4))
        else $error("forward value not on pin");

    fc_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_fc_frame == 4'h0) |=> $stable(q.fc_hold))
        else $error("forward value changed without frame");

    fc_delay_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_srst [*3] |-> fc_out == $past(q.fc_hold, 2))
        else $error("forward latency wrong");

    bc_slot_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !$stable(o_bc_slot) |-> o_bc_tick)
        else $error("slot changed between frames");

    status_read_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 8'h0e) |=> o_reg_rdata == $past(q.status))
        else $error("status read wrong");

    ctl_oe_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == 8'h10) ##1 !i_srst
            |=> o_pin_oe[0] == $past(i_reg_wdata[0], 2))
        else $error("pin 0 drive not following write");

    fsync_pin_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (q.ctl[2][2:1] == 2'b10) |=> o_pin_out[2] == $past(i_fsync_int))
        else $error("frame sync not on pin");

    rdata_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read answer not held");
endmodule
`default_nettype wire

// ===== rtl/gpm_sync.sv
`default_nettype none
module gpm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    // ----------------------------------------
    // Three stages, accept when two agree
    // ----------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } gpm_sync_t;
    gpm_sync_t q;
    gpm_sync_t d;

    // Next state; s1 feeds s2 only
    always_comb begin
        d = q;
        d.s1 = i_async;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = (q.s2 & ~(q.s2 ^ q.s3)) | (q.lvl & (q.s2 ^ q.s3));
        if (i_srst) begin
            d = '0;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        q <= d;
    end

    assign o_level = q.lvl;

    agree_take_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (q.s2 == q.s3) |=> (o_level == $past(q.s2)))
        else $error("level not taken after agreement");
endmodule
`default_nettype wire

// ===== test/gpm_fc_model.sv
`default_nettype none
// ----------------------------------------
// Remote serializer forward frames
// ----------------------------------------
module gpm_fc_model (
    input  wire logic        i_ref_clk,
    output logic      [3:0]  o_fc_frame,
    output logic      [15:0] o_fc_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet link at time zero
    initial begin
        o_fc_frame = 4'h0;
        o_fc_data  = 16'h0000;
    end

    // Idle gap, then one frame on the masked ports
    task automatic send(input logic [3:0] mask, input logic [15:0] d);
        repeat (2) @(negedge i_ref_clk);
        o_fc_frame = mask;
        o_fc_data  = d;
        @(negedge i_ref_clk);
        o_fc_frame = 4'h0;
        o_fc_data  = ~d; // Stale data never looks valid
    endtask
endmodule
`default_nettype wire

// ===== test/gpm_port_test.sv
`default_nettype none
module gpm_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic        clk;
    logic        i_srst;
    logic [7:0]  i_reg_addr;
    logic [7:0]  i_reg_wdata;
    logic        i_reg_wr;
    logic        i_reg_rd;
    logic [1:0]  i_rx_port_sel;
    logic [7:0]  o_reg_rdata;
    logic [7:0]  i_pin_in;
    logic [7:0]  o_pin_out;
    logic [7:0]  o_pin_oe;
    logic [7:0]  o_pin_ie;
    logic [7:0]  o_pin_pd_en;
    logic [3:0]  fc_frame;
    logic [15:0] fc_data;
    logic [7:0]  i_fc_linked_count;
    logic        i_fsync_int;
    logic        i_ext_fsync;
    logic        i_int_ctl;
    logic [1:0]  i_bc_rate;
    logic        o_bc_tick;
    logic [15:0] o_bc_slot;
    logic [7:0]  rv;
    int          bad_count;
    int          samples_checked;

    gpm_port gpm_port_inst (
        .i_ref_clk(clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_rx_port_sel(i_rx_port_sel), .o_reg_rdata(o_reg_rdata),
        .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pin_ie(o_pin_ie), .o_pin_pd_en(o_pin_pd_en), .i_fc_frame(fc_frame),
        .i_fc_data(fc_data), .i_fc_linked_count(i_fc_linked_count),
        .i_fsync_int(i_fsync_int), .i_ext_fsync(i_ext_fsync),
        .i_int_ctl(i_int_ctl), .i_bc_rate(i_bc_rate), .o_bc_tick(o_bc_tick),
        .o_bc_slot(o_bc_slot));

    gpm_fc_model gpm_fc_model_inst (
        .i_ref_clk(clk), .o_fc_frame(fc_frame), .o_fc_data(fc_data));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Write, then let the config reach the pads
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        i_reg_addr  = a;
        i_reg_wdata = d;
        i_reg_wr    = 1'b1;
        @(negedge clk);
        i_reg_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        i_reg_addr = a;
        i_reg_rd   = 1'b1;
        @(negedge clk);
        i_reg_rd = 1'b0;
        @(negedge clk);
        d = o_reg_rdata;
    endtask

    task automatic wait_pin(input int b, input logic v);
        int n;
        n = 0;
        while (o_pin_out[b] !== v && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk("pin level", o_pin_out[b], v);
        if (o_pin_out[b] !== v) finish_test();
    endtask

    // Cycles up to and including the next frame pulse
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (o_bc_tick !== 1'b1 && n < 600);
        if (n >= 600) begin
            bad_count++;
            finish_test();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(8'h0f, rv); chk("in_dis rst", rv, 8'h00);
        rd(8'hbe, rv); chk("pd_dis rst", rv, 8'h00);
        rd(8'h10, rv); chk("ctl rst", rv, 8'h00);
        wr(8'h0f, 8'hff);
        rd(8'h0f, rv); chk("in_dis od", rv, 8'hf7);
        chk("ie all off", o_pin_ie, 8'h08);
        wr(8'hbe, 8'hff);
        rd(8'hbe, rv); chk("pd_dis od", rv, 8'hf7);
        chk("pd all off", o_pin_pd_en, 8'h00);
        wr(8'h0f, 8'h06);
        chk("ie pins 1 2", o_pin_ie, 8'hf9);
        wr(8'hbe, 8'h00);
        wr(8'h0f, 8'h00);
        wr(8'h0e, 8'hff); // Read-only place
        rd(8'h20, rv); chk("unmapped", rv, 8'h00);
    endtask

    task automatic t_status();
        rd(8'h0e, rv); chk("status in", rv, 8'ha4);
        wr(8'h0f, 8'h01);
        wr(8'h10, 8'h09);
        chk("oe pin0", o_pin_oe, 8'h01);
        chk("out pin0", o_pin_out, 8'h01);
        rd(8'h0e, rv); chk("status out", rv, 8'ha5);
    endtask

    task automatic t_fc(input logic [1:0] code, input int n);
        int k;
        i_fc_linked_count = {2'b00, code, 4'h0};
        for (k = 0; k < 6; k++) gpm_fc_model_inst.send(4'h4, 16'h0000);
        k = 0;
        while (o_pin_out[1] !== 1'b1 && k < 6) begin
            gpm_fc_model_inst.send(4'h4, 16'h0200);
            repeat (4) @(negedge clk);
            k++;
        end
        chk("fc taken", o_pin_out[1], 1'b1);
        if (o_pin_out[1] !== 1'b1) finish_test();
        for (k = 1; k <= n; k++) begin
            gpm_fc_model_inst.send(4'h4, 16'h0000);
            // Pin moves on the fourth edge after the frame
            repeat (2) @(negedge clk);
            chk("fc held", o_pin_out[1], 1'b1);
            @(negedge clk);
            chk("fc sample", o_pin_out[1], (k == n) ? 1'b0 : 1'b1);
        end
    endtask

    task automatic t_internal();
        wr(8'h0f, 8'h07);
        wr(8'h13, 8'h01);
        chk("od pull", o_pin_oe[3], 1'b1);
        wr(8'h13, 8'h09);
        chk("od free", o_pin_oe[3], 1'b0);
        wr(8'h12, 8'h05);
        i_fsync_int = 1'b1;
        wait_pin(2, 1'b1);
        i_fsync_int = 1'b0;
        wait_pin(2, 1'b0);
        wr(8'h12, 8'h07);
        i_int_ctl = 1'b1;
        wait_pin(2, 1'b1);
        i_int_ctl = 1'b0;
        wait_pin(2, 1'b0);
    endtask

    task automatic t_backch();
        int n;
        int r;
        int per[4] = '{12, 60, 240, 240};
        i_rx_port_sel = 2'h1;
        wr(8'h6e, 8'h55);
        wr(8'h6f, 8'h98);
        rd(8'h6e, rv); chk("bank 1 a", rv, 8'h55);
        rd(8'h6f, rv); chk("bank 1 b", rv, 8'h98);
        i_rx_port_sel = 2'h0;
        rd(8'h6e, rv); chk("bank 0 a", rv, 8'h00);
        i_pin_in    = 8'h20;
        i_fsync_int = 1'b1;
        wait_tick(n);
        wait_tick(n);
        chk("slots pin", o_bc_slot, 16'h0070);
        i_pin_in    = 8'h00;
        i_fsync_int = 1'b0;
        i_ext_fsync = 1'b1;
        wait_tick(n);
        wait_tick(n);
        chk("slots ext", o_bc_slot, 16'h0080);
        for (r = 0; r < 4; r++) begin
            i_bc_rate = r[1:0];
            wait_tick(n);
            wait_tick(n);
            chk("bc period", 16'(n), 16'(per[r]));
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        bad_count = 0;
        samples_checked = 0;
        i_srst = 1'b1;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_rx_port_sel = 2'h0;
        i_pin_in = 8'ha4;
        i_fc_linked_count = 8'h00;
        i_fsync_int = 1'b0;
        i_ext_fsync = 1'b0;
        i_int_ctl = 1'b0;
        i_bc_rate = 2'h0;
        repeat (6) @(negedge clk);
        i_srst = 1'b0;
        chk("ie rst", o_pin_ie, 8'hff);
        chk("pd rst", o_pin_pd_en, 8'hf7);
        chk("oe rst", o_pin_oe, 8'h00);
        t_regs();
        t_status();
        wr(8'h0f, 8'h03);
        wr(8'h11, 8'h93);
        t_fc(2'h0, 1);
        t_fc(2'h1, 2);
        t_fc(2'h2, 5);
        t_fc(2'h3, 5);
        t_internal();
        t_backch();
        finish_test();
    end
endmodule
`default_nettype wire
